// ---- rtl/cptg_top.sv ----
/*
  Chain of four pulse generators; each stage drives the next as its child.
  Assumes the master enable comes from a pin and settings are static-ish
  words on the sample clock; times are in tenths of a millisecond.
*/
`timescale 1ns/10ps
module cptg_top
    import cptg_pkg::*;
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // master enable
    input  wire logic                          masterEn,
    input  wire cptg_pkg::cptg_ctrl_e          masterCtrl,
    input  wire logic                          masterClamp,
    // per-stage settings, stage 0 is the top of the chain
    input  wire cptg_pkg::cptg_ctrl_e [NUM_GEN-1:0] genCtrl,
    input  wire logic [NUM_GEN-1:0]            genClamp,
    input  wire cptg_pkg::cptg_fmt_e [NUM_GEN-1:0]  genFmt,
    input  wire logic [NUM_GEN-1:0]            genDelayEn,
    input  wire logic [NUM_GEN-1:0]            genSeqEn,
    input  wire logic [NUM_GEN-1:0][CNT_W-1:0] genPeriod,
    input  wire logic [NUM_GEN-1:0][CNT_W-1:0] genWidth,
    input  wire logic [NUM_GEN-1:0][CNT_W-1:0] genDelay,
    input  wire logic [NUM_GEN-1:0][AMP_W-1:0] genAmp,
    input  wire logic [NUM_GEN-1:0][31:0]      genPattern,
    // outputs
    output logic [NUM_GEN-1:0]                 trainLogic,
    output logic [NUM_GEN-1:0][AMP_W-1:0]      trainValue,
    output logic                               active
);
    logic             enSync1_reg;
    logic             enSync2_reg;
    logic             enPrev_reg;
    logic [NUM_GEN:0] pulse;
    logic [NUM_GEN-1:0] busy;
    logic [NUM_GEN-1:0] gated;
    logic [NUM_GEN-1:0] outPrev_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            enSync1_reg <= 1'b0;
            enSync2_reg <= 1'b0;
            enPrev_reg <= 1'b0;
        end
        else
        begin
            enSync1_reg <= masterEn;
            enSync2_reg <= enSync1_reg;
            enPrev_reg <= enSync2_reg;
        end
    end

    // the master enable acts as stage -1 of the chain
    assign pulse[0] = enSync2_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_GEN; g++)
        begin : gStage
            logic [4:0]  step_reg;
            logic [CNT_W-1:0] perT;
            logic [CNT_W-1:0] widT;
            logic [CNT_W-1:0] perC;
            logic [CNT_W-1:0] widC;
            cptg_ctrl_e  pCtrl;
            logic        pClamp;
            logic        pRise;
            logic        pFall;
            logic        pLevel;
            logic        trig;
            logic        start;
            logic        clampNow;
            logic [4:0]  stepCnt;
            logic        stepOk;
            logic [4:0]  stepNext;
            logic        gOut;
            logic        gOutQ;

            // parent settings govern this child
            if (g == 0)
            begin : gMaster
                assign pCtrl = masterCtrl;
                assign pClamp = masterClamp;
                assign pRise = enSync2_reg && !enPrev_reg;
                assign pFall = !enSync2_reg && enPrev_reg;
                assign pLevel = pulse[0];
            end
            else
            begin : gChild
                assign pCtrl = genCtrl[g-1];
                assign pClamp = genClamp[g-1];
                assign pRise = gated[g-1] && !outPrev_reg[g-1];
                assign pFall = !gated[g-1] && outPrev_reg[g-1];
                assign pLevel = gated[g-1];
            end

            // clip timing to documented bounds, then convert to ticks
            assign perC = (genPeriod[g] < MIN_PERIOD_TENTHS) ? MIN_PERIOD_TENTHS :
                          (genPeriod[g] > MAX_PERIOD_TENTHS) ? MAX_PERIOD_TENTHS :
                          genPeriod[g];
            assign widC = (genWidth[g] < MIN_WIDTH_TENTHS) ? MIN_WIDTH_TENTHS
                                                           : genWidth[g];
            assign perT = CNT_W'(perC * TICKS_PER_TENTH_MS);
            assign widT = CNT_W'(widC * TICKS_PER_TENTH_MS);

            // triggered: rise starts; strobe/timer: rise starts too, level holds
            assign trig = pRise;
            assign clampNow = pFall && pClamp && (pCtrl != CTRL_TRIG);

            // sequencer: flag bit 0 is the first trigger
            assign stepCnt = (genPattern[g][SEQ_CNT_LSB+4:SEQ_CNT_LSB] > SEQ_MAX_STEPS)
                             ? SEQ_MAX_STEPS
                             : genPattern[g][SEQ_CNT_LSB+4:SEQ_CNT_LSB];
            assign stepOk = !genSeqEn[g] || (stepCnt == 5'h00) ||
                            genPattern[g][step_reg[3:0]];
            assign stepNext = (step_reg + 5'h01 >= stepCnt) ? 5'h00
                                                            : step_reg + 5'h01;
            assign start = trig && stepOk;

            always_ff @(posedge clk)
            begin
                if (rst)
                    step_reg <= 5'h00;
                else if (trig && genSeqEn[g])
                    step_reg <= stepNext;
            end

            cptg_gen uGen (
                .clk         (clk),
                .rst         (rst),
                .startPulse  (start),
                .runLevel    ((pCtrl == CTRL_TRIG) ? 1'b1 : pLevel),
                .clampNow    (clampNow),
                .ctrlType    (genCtrl[g]),
                .periodTicks (perT),
                .widthTicks  (widT),
                .delayTicks  (CNT_W'(genDelay[g] * TICKS_PER_TENTH_MS)),
                .delayEn     (genDelayEn[g]),
                .pulseOut    (gOut),
                .busy        (busy[g])
            );
            assign gated[g] = gOut;
            // mask the clamped child at once so it drops in the parent's falling sample
            assign gOutQ = gOut && !clampNow;
            assign pulse[g+1] = gOut;

            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    outPrev_reg[g] <= 1'b0;
                    trainLogic[g] <= 1'b0;
                    trainValue[g] <= '0;
                end
                else
                begin
                    outPrev_reg[g] <= gOut;
                    trainLogic[g] <= gOutQ;
                    trainValue[g] <= (gOutQ && genFmt[g] != OUT_LOGIC) ? genAmp[g]
                                     : {{(AMP_W-1){1'b0}}, gOutQ};
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (rst)
            active <= 1'b0;
        else
            active <= |busy;
    end
endmodule

// ---- rtl/cptg_pkg.sv ----
/*
  Shared constants and types for the chained pulse train generator.
  Assumes a single 20 MHz sample clock; all times are converted to ticks.
*/
package cptg_pkg;
    localparam int CLK_HZ = 20000000;
    localparam int NUM_GEN = 4;
    localparam int CNT_W = 32;
    localparam int AMP_W = 32;
    // time in units of 0.1 ms (period 0.100 .. 100000.000 ms)
    localparam int TENTH_MS_NUM = 1;
    localparam int TENTH_MS_DEN = 10000;
    localparam logic [CNT_W-1:0] TICKS_PER_TENTH_MS =
        CNT_W'((CLK_HZ * TENTH_MS_NUM) / TENTH_MS_DEN);
    localparam logic [CNT_W-1:0] MIN_PERIOD_TENTHS = 32'h0000_0001;
    localparam logic [CNT_W-1:0] MAX_PERIOD_TENTHS = 32'h000F_4240;
    localparam logic [CNT_W-1:0] MIN_WIDTH_TENTHS = 32'h0000_0001;
    localparam int SEQ_CNT_LSB = 16;
    localparam int SEQ_FLAG_W = 16;
    localparam logic [4:0] SEQ_MAX_STEPS = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {CTRL_TRIG, CTRL_STROBE, CTRL_TIMER} cptg_ctrl_e;
    typedef enum logic [1:0] {OUT_LOGIC, OUT_FLOAT, OUT_INT} cptg_fmt_e;
endpackage

// ---- rtl/cptg_gen.sv ----
/*
  One pulse generator stage: counts period, width and delay in sample ticks.
  Assumes start/run controls arrive on the same clock from the parent stage.
*/
`timescale 1ns/10ps
module cptg_gen
    import cptg_pkg::*;
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // control from parent, plus this stage's own control type
    input  wire logic             startPulse,
    input  wire logic             runLevel,
    input  wire logic             clampNow,
    input  wire cptg_ctrl_e       ctrlType,
    // timing in ticks
    input  wire logic [CNT_W-1:0] periodTicks,
    input  wire logic [CNT_W-1:0] widthTicks,
    input  wire logic [CNT_W-1:0] delayTicks,
    input  wire logic             delayEn,
    // state
    output logic                  pulseOut,
    output logic                  busy
);
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_HIGH, ST_LOW} cptg_st_e;
    cptg_st_e         st_reg;
    cptg_st_e         st_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             oneShot_reg;

    wire logic [CNT_W-1:0] firstDelay = delayEn ? delayTicks : CNT_ZERO;
    wire logic             cntDone = (cnt_reg <= CNT_ONE);
    wire logic [CNT_W-1:0] lowTicks = (periodTicks > widthTicks) ?
                                      (periodTicks - widthTicks) : CNT_ONE;
    // repeat unless own type is timer: while the parent lets us run (strobe or timer) or always (triggered)
    wire logic             mayRepeat = !oneShot_reg && runLevel;

    always_comb
    begin
        st_next = st_reg;
        cnt_next = cnt_reg - CNT_ONE;
        case (st_reg)
            ST_IDLE:
            begin
                cnt_next = cnt_reg;
                if (startPulse)
                begin
                    st_next = (firstDelay != CNT_ZERO) ? ST_DELAY : ST_HIGH;
                    cnt_next = (firstDelay != CNT_ZERO) ? firstDelay : widthTicks;
                end
            end
            ST_DELAY:
                if (cntDone)
                begin
                    st_next = ST_HIGH;
                    cnt_next = widthTicks;
                end
            ST_HIGH:
                if (cntDone)
                begin
                    st_next = mayRepeat ? ST_LOW : ST_IDLE;
                    cnt_next = lowTicks;
                end
            ST_LOW:
                if (!runLevel)
                    st_next = ST_IDLE;
                else if (cntDone)
                begin
                    st_next = ST_HIGH;
                    cnt_next = widthTicks;
                end
            default:
                st_next = ST_IDLE;
        endcase
        if (clampNow)
            st_next = ST_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_reg <= ST_IDLE;
            cnt_reg <= CNT_ZERO;
            oneShot_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            if (startPulse && st_reg == ST_IDLE)
                oneShot_reg <= (ctrlType == CTRL_TIMER);
        end
    end

    assign pulseOut = (st_reg == ST_HIGH);
    assign busy = (st_reg != ST_IDLE);
endmodule

// ---- test/cptg_top_monitor.sv ----
/*
  Port checker for the pulse chain top.
  Assumes bind to cptg_top; settings change only while the chain is idle.
*/
`timescale 1ns/10ps
module cptg_top_monitor
    import cptg_pkg::*;
(
    // clock and reset
    input wire logic                          clk,
    input wire logic                          rst,
    // settings
    input wire logic                          masterEn,
    input wire logic                          masterClamp,
    input wire cptg_ctrl_e [NUM_GEN-1:0]      genCtrl,
    input wire logic [NUM_GEN-1:0]            genClamp,
    input wire cptg_fmt_e [NUM_GEN-1:0]       genFmt,
    input wire logic [NUM_GEN-1:0]            genDelayEn,
    input wire logic [NUM_GEN-1:0][CNT_W-1:0] genWidth,
    input wire logic [NUM_GEN-1:0][AMP_W-1:0] genAmp,
    // outputs
    input wire logic [NUM_GEN-1:0]            trainLogic,
    input wire logic [NUM_GEN-1:0][AMP_W-1:0] trainValue,
    input wire logic                          active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [CNT_W-1:0] hiCnt_reg;
    always_ff @(posedge clk)
    begin
        if (rst || !trainLogic[0])
            hiCnt_reg <= CNT_ZERO;
        else
            hiCnt_reg <= hiCnt_reg + CNT_ONE;
    end
    property p_width;
        $fell(trainLogic[0]) && !masterClamp |-> hiCnt_reg == genWidth[0] * TICKS_PER_TENTH_MS;
    endproperty
    a_width: assert property (p_width) else $error("stage 0 high time wrong");
    property p_fmt;
        trainLogic[0] |-> trainValue[0] == (genFmt[0] == OUT_LOGIC ? CNT_ONE : genAmp[0]);
    endproperty
    a_fmt: assert property (p_fmt) else $error("high value wrong");
    property p_low;
        !trainLogic[0] |-> trainValue[0] == CNT_ZERO;
    endproperty
    a_low: assert property (p_low) else $error("low value not zero");
    property p_act;
        trainLogic[0] && $past(trainLogic[0]) |-> active;
    endproperty
    a_act: assert property (p_act) else $error("active low during pulse");
    property p_idle;
        (!masterEn)[*6] ##0 !active |=> !trainLogic[0];
    endproperty
    a_idle: assert property (p_idle) else $error("pulse without enable");
    property p_child;
        $rose(trainLogic[1]) && !genDelayEn[1]
            |-> trainLogic[0] || $past(trainLogic[0]) || $past(trainLogic[0], 2);
    endproperty
    a_child: assert property (p_child) else $error("child onset outside parent");
    property p_clamp;
        $fell(trainLogic[0]) && genClamp[0] && genCtrl[0] == CTRL_STROBE |-> !trainLogic[1];
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamped child kept running");
    property p_reset;
        disable iff (1'b0) rst |=> trainLogic == 4'h0 && !active;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs busy after reset");
    c_width: cover property ($fell(trainLogic[0]) && !masterClamp);
    c_child: cover property ($rose(trainLogic[1]));
    c_clamp: cover property ($fell(trainLogic[0]) && genClamp[0]);
endmodule

// ---- test/cptg_sink.sv ----
/*
  Downstream stimulus sink: tallies pulse onsets on each train line.
  Assumes train lines are registered on the same sample clock.
*/
`timescale 1ns/10ps
module cptg_sink
    import cptg_pkg::*;
(
    // clock and clear
    input  wire logic               clk,
    input  wire logic               clr,
    // train lines and tallies
    input  wire logic [NUM_GEN-1:0] level,
    output logic [NUM_GEN-1:0][7:0] onsets
);
    logic [NUM_GEN-1:0] last;
    always_ff @(posedge clk)
    begin
        last <= level;
        for (int g = 0; g < NUM_GEN; g++)
        begin
            if (clr)
                onsets[g] <= 8'h00;
            else if (level[g] && !last[g])
                onsets[g] <= onsets[g] + 8'h01;
        end
    end
endmodule

// ---- test/test_chained_pulse_train_generator.sv ----
/*
  Self-checking bench for the pulse chain top with a downstream sink.
  Assumes 2000 sample ticks per tenth of a millisecond.
*/
`timescale 1ns/10ps
module test_chained_pulse_train_generator;
    import cptg_pkg::*;
    localparam int T = 2000;
    logic                     clk, rst, masterEn, masterClamp, active;
    cptg_ctrl_e               masterCtrl;
    cptg_ctrl_e [3:0]         genCtrl;
    cptg_fmt_e [3:0]          genFmt;
    logic [3:0]               genClamp, genDelayEn, genSeqEn, trainLogic;
    logic [3:0][31:0]         genPeriod, genWidth, genDelay, genAmp, genPattern, trainValue;
    logic [3:0][7:0]          onsets;
    int                       num_errors, n_checks, cyc, n, exp;
    cptg_fmt_e                rowFmt[4] = '{OUT_LOGIC, OUT_FLOAT, OUT_INT, OUT_LOGIC};
    logic [31:0]              rowAmp[4] = '{32'h55, 32'h3F80_0000, 32'h7, 32'h55};
    logic [31:0]              rowExp[4] = '{32'h1, 32'h3F80_0000, 32'h7, 32'h1};
    logic                     rowDel[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    cptg_top cptg_top_i (.clk(clk), .rst(rst), .masterEn(masterEn), .masterCtrl(masterCtrl),
        .masterClamp(masterClamp), .genCtrl(genCtrl), .genClamp(genClamp), .genFmt(genFmt),
        .genDelayEn(genDelayEn), .genSeqEn(genSeqEn), .genPeriod(genPeriod),
        .genWidth(genWidth), .genDelay(genDelay), .genAmp(genAmp), .genPattern(genPattern),
        .trainLogic(trainLogic), .trainValue(trainValue), .active(active));
    cptg_sink cptg_sink_i (.clk(clk), .clr(rst), .level(trainLogic), .onsets(onsets));
    task automatic check(input logic [31:0] got, input logic [31:0] want, input string m);
        n_checks++;
        if (got !== want)
        begin
            num_errors++;
            $display("ERROR %0t %s got %0h want %0h", $time, m, got, want);
        end
    endtask
    task automatic waitRise(input int g, input int lim, output int c);
        c = 0;
        while (trainLogic[g] !== 1'b1 && c < lim)
        begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic highLen(input int g, output int c);
        c = 0;
        while (trainLogic[g] === 1'b1 && c < 9 * T)
        begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic doReset();
        rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 100000)
        begin
            num_errors++;
            $display("ERROR %0t run hung", $time);
            results();
        end
    end
    initial
    begin
        {masterEn, masterClamp, genClamp, genDelayEn, genSeqEn} = '0;
        masterCtrl = CTRL_TRIG;
        genCtrl = {4{CTRL_TIMER}};
        genFmt = {4{OUT_LOGIC}};
        genPeriod = {4{32'h2}};
        genWidth = {4{32'h1}};
        {genDelay, genAmp, genPattern} = '0;
        @(negedge clk);
        doReset();
        check({active, trainLogic}, 5'h00, "reset");
        for (int r = 0; r < 4; r++)
        begin
            genFmt[0] = rowFmt[r];
            genAmp[0] = rowAmp[r];
            genDelayEn[0] = rowDel[r];
            genDelay[0] = {31'h0, rowDel[r]};
            masterEn = 1'b1;
            waitRise(0, 3 * T, n);
            exp = rowDel[r] ? T : 0;
            check(n >= exp && n < exp + 8, 1, "onset");
            masterEn = 1'b0;
            @(negedge clk);
            check(trainValue[0], rowExp[r], "value");
            highLen(0, n);
            check(n + 1, T, "width");
            waitRise(0, 3 * T / 2, n);
            check(n, 3 * T / 2, "repeat");
            check(active, 0, "idle");
            $display("row %0d done", r);
        end
        doReset();
        masterCtrl = CTRL_STROBE;
        genCtrl[0] = CTRL_TRIG;
        genSeqEn[1] = 1'b1;
        genPattern[1] = 32'h0006_0033;
        masterEn = 1'b1;
        for (int k = 0; k < 7; k++)
        begin
            waitRise(0, 3 * T, n);
            repeat (20) @(negedge clk);
            check(trainLogic[1], genPattern[1][k % 6], "step");
            highLen(0, n);
        end
        masterEn = 1'b0;
        waitRise(0, 3 * T / 2, n);
        check(n, 3 * T / 2, "strobe stop");
        check(onsets[1], 8'h05, "step count");
        $display("sequence done");
        genSeqEn[1] = 1'b0;
        genCtrl[0] = CTRL_STROBE;
        genCtrl[1] = CTRL_TRIG;
        genWidth[1] = 32'h3;
        genPeriod[1] = 32'h4;
        for (int c = 0; c < 2; c++)
        begin
            genClamp[0] = c[0];
            masterEn = 1'b1;
            waitRise(1, 3 * T, n);
            masterEn = 1'b0;
            highLen(1, n);
            exp = c ? T : 3 * T;
            check(n > exp - 8 && n <= exp, 1, "child high");
            waitRise(1, 2 * T, n);
            check(n, 2 * T, "child stops");
            $display("clamp %0d done", c);
        end
        results();
    end
endmodule
bind cptg_top cptg_top_monitor cptg_top_monitor_i (.clk(clk), .rst(rst), .masterEn(masterEn),
    .masterClamp(masterClamp), .genCtrl(genCtrl), .genClamp(genClamp), .genFmt(genFmt),
    .genDelayEn(genDelayEn), .genWidth(genWidth), .genAmp(genAmp),
    .trainLogic(trainLogic), .trainValue(trainValue), .active(active));
